// ===== logic/pbc_pkg.sv
// package for the bridge control upper half: offsets, field positions, reset values
// assumes a single 32-bit configuration dword at the bridge control offset
package pbc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PBC_BRIDGE_CONTROL_OFS = 8'h3c;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PBC_PERR_RESP_BIT = 16;
  localparam int PBC_SERR_FWD_BIT = 17;
  localparam int PBC_ISA_FILT_BIT = 18;
  localparam int PBC_VGA_FWD_BIT = 19;
  localparam int PBC_MABORT_MODE_BIT = 21;
  localparam int PBC_SEC_RESET_BIT = 22;
  localparam int PBC_FAST_B2B_BIT = 23;
  localparam int PBC_SPARE0_BIT = 24;
  localparam int PBC_SPARE1_BIT = 25;
  localparam int PBC_MTO_STAT_BIT = 26;
  localparam int PBC_DISC_STAT_BIT = 27;
  // ----------------------------------------------------------------
  // reset values and address constants
  // ----------------------------------------------------------------
  localparam logic [7:0] PBC_CTRL_RESET = 8'h00;
  localparam logic [1:0] PBC_STAT_RESET = 2'h0;
  localparam logic [1:0] PBC_SPARE_RESET = 2'h0;
  localparam logic [31:0] PBC_ALL_ONES = 32'hffff_ffff;
  localparam logic [9:0] PBC_ISA_ALIAS_LOW = 10'h100;
  // ----------------------------------------------------------------
  // state of the secondary-reset sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PBC_RST_IDLE = 2'b01,
    PBC_RST_HOLD = 2'b10
  } pbc_rst_state_type;
endpackage

// ===== logic/pbc_wc_flag.sv
// one write-one-to-clear status flag, set wins over clear
// assumes the event input is already synchronous to core_clk
module pbc_wc_flag
  import pbc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic set_evt,
  input wire logic clr_req,
  output logic flag
);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (set_evt) begin
      flag <= 1'b1; // [RULE15]
    end else if (clr_req) begin
      flag <= 1'b0; // [RULE15]
    end
  end
endmodule

// ===== logic/pbc_bridge_control.sv
// upper half of the bridge control configuration dword and the datapath decisions it steers
// assumes config accesses are single-cycle strobes on core_clk; pins pass two flip-flops
//
// Behaviour
// [RULE1] parity control clear ignores secondary parity errors; set detects and reports them
// [RULE2] system-error forward bit gates either secondary error onto the primary output
// [RULE3] isa filter blocks downstream io in window, first 64KB, last 768 of 1KB
// [RULE4] isa filter set passes upstream secondary io in last 768 of each 1KB
// [RULE5] isa filter clear forwards every io address within the base/limit window
// [RULE6] vga bit forwards vga memory and io downstream regardless of windows
// [RULE7] abort mode clear: master abort unreported, reads all ones, writes dropped
// [RULE8] abort mode set: report by target abort, else primary system error if enabled
// [RULE9] secondary reset bit drives both secondary bus resets while it stays set
// [RULE10] fast back-to-back to different targets allowed only when its bit is set
// [RULE11] master-timeout status sets on either master timeout counter expiry
// [RULE12] discard status sets and asserts primary system error if enabled on any discard expiry
// [RULE13] bit 20 and bits 31-28 always read zero
// [RULE14] bits 24 and 25 are plain storage with no effect, reset zero
// [RULE15] writing one clears a status bit, writing zero leaves it
module pbc_bridge_control
  import pbc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  // configuration access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  // secondary parity
  input wire logic sec_parity_err,
  output logic sec_parity_report,
  // system error pins
  input wire logic sec1_system_error_n,
  input wire logic sec2_system_error_n,
  input wire logic pri_serr_enable,
  output logic pri_system_error_n,
  // io/memory forwarding decision
  input wire logic [31:0] io_addr,
  input wire logic io_in_window,
  input wire logic vga_addr_hit,
  output logic fwd_down,
  output logic fwd_up,
  // secondary master abort
  input wire logic sec_master_abort,
  input wire logic abort_target_possible,
  output logic abort_signal_target,
  output logic abort_read_all_ones,
  output logic abort_discard_write,
  output logic [31:0] abort_read_data,
  // secondary reset and fast back-to-back
  output logic sec1_bus_reset_n,
  output logic sec2_bus_reset_n,
  output logic fast_b2b_allowed,
  // timers
  input wire logic pri_mto_expired,
  input wire logic sec_mto_expired,
  input wire logic pri_disc_expired,
  input wire logic sec1_disc_expired,
  input wire logic sec2_disc_expired
);
  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic pbc_hit(input logic [7:0] a);
    return a == PBC_BRIDGE_CONTROL_OFS;
  endfunction

  // last 768 bytes of a 1KB block: offset within block at or above 0x100
  function automatic logic pbc_isa_alias(input logic [31:0] a);
    return a[9:0] >= PBC_ISA_ALIAS_LOW;
  endfunction

  logic [7:0] ctrl_r; // bits 23:16
  logic [1:0] spare_r; // bits 25:24
  logic wr_hit;
  logic mto_flag;
  logic disc_flag;
  logic [1:0] serr_meta_r;
  logic [1:0] serr_sync_r;
  logic serr_fwd_nxt;
  logic pri_serr_r;
  pbc_rst_state_type rst_state_r;
  pbc_rst_state_type rst_state_nxt;

  assign wr_hit = cfg_wr && pbc_hit(cfg_addr);

  // ----------------------------------------------------------------
  // control storage, byte lane 2
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= PBC_CTRL_RESET;
    end else if (wr_hit && cfg_be[2]) begin
      ctrl_r <= cfg_wdata[23:16];
    end
  end

  // reserved lane-3 storage: kept so a read-modify-write by software round-trips
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      spare_r <= PBC_SPARE_RESET; // [RULE14]
    end else if (wr_hit && cfg_be[3]) begin
      spare_r <= cfg_wdata[PBC_SPARE1_BIT:PBC_SPARE0_BIT]; // [RULE14]
    end
  end

  // ----------------------------------------------------------------
  // status flags, byte lane 3
  // ----------------------------------------------------------------
  pbc_wc_flag u_mto (
    .core_clk(core_clk),
    .rst(rst),
    .set_evt(pri_mto_expired || sec_mto_expired), // [RULE11]
    .clr_req(wr_hit && cfg_be[3] && cfg_wdata[PBC_MTO_STAT_BIT]),
    .flag(mto_flag)
  );

  pbc_wc_flag u_disc (
    .core_clk(core_clk),
    .rst(rst),
    .set_evt(pri_disc_expired || sec1_disc_expired || sec2_disc_expired), // [RULE12]
    .clr_req(wr_hit && cfg_be[3] && cfg_wdata[PBC_DISC_STAT_BIT]),
    .flag(disc_flag)
  );

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_rdata <= 32'h0000_0000;
    end else if (cfg_rd) begin
      cfg_rdata <= 32'h0000_0000;
      if (pbc_hit(cfg_addr)) begin
        cfg_rdata[23:16] <= ctrl_r & 8'hef; // [RULE13]
        cfg_rdata[PBC_SPARE1_BIT:PBC_SPARE0_BIT] <= spare_r; // [RULE14]
        cfg_rdata[PBC_MTO_STAT_BIT] <= mto_flag;
        cfg_rdata[PBC_DISC_STAT_BIT] <= disc_flag;
      end
    end
  end

  // ----------------------------------------------------------------
  // parity and system error
  // ----------------------------------------------------------------
  assign sec_parity_report = ctrl_r[PBC_PERR_RESP_BIT - 16] && sec_parity_err; // [RULE1]

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      serr_meta_r <= 2'h3;
      serr_sync_r <= 2'h3;
    end else begin
      serr_meta_r <= {sec2_system_error_n, sec1_system_error_n};
      serr_sync_r <= serr_meta_r;
    end
  end

  // forwarded secondary errors are further qualified by the primary enable
  assign serr_fwd_nxt = ctrl_r[PBC_SERR_FWD_BIT - 16] && !(&serr_sync_r); // [RULE2]

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pri_serr_r <= 1'b0;
    end else begin
      pri_serr_r <= pri_serr_enable && (serr_fwd_nxt || (pri_disc_expired || sec1_disc_expired
        || sec2_disc_expired) // [RULE12]
        || (ctrl_r[PBC_MABORT_MODE_BIT - 16] && sec_master_abort && !abort_target_possible)); // [RULE8]
    end
  end
  assign pri_system_error_n = !pri_serr_r;

  // ----------------------------------------------------------------
  // forwarding filters
  // ----------------------------------------------------------------
  always_comb begin
    fwd_down = io_in_window; // [RULE5]
    if (ctrl_r[PBC_ISA_FILT_BIT - 16] && io_addr[31:16] == 16'h0000 && pbc_isa_alias(io_addr)) begin
      fwd_down = 1'b0; // [RULE3]
    end
    if (ctrl_r[PBC_VGA_FWD_BIT - 16] && vga_addr_hit) begin
      fwd_down = 1'b1; // [RULE6]
    end
  end

  // upstream: alias addresses go up when filter set, else addresses not forwarded downstream go up
  assign fwd_up = (ctrl_r[PBC_ISA_FILT_BIT - 16] && pbc_isa_alias(io_addr)) || !fwd_down; // [RULE4]

  // ----------------------------------------------------------------
  // master abort handling
  // ----------------------------------------------------------------
  assign abort_signal_target = ctrl_r[PBC_MABORT_MODE_BIT - 16] && sec_master_abort
    && abort_target_possible; // [RULE8]
  assign abort_read_all_ones = !ctrl_r[PBC_MABORT_MODE_BIT - 16] && sec_master_abort; // [RULE7]
  assign abort_discard_write = !ctrl_r[PBC_MABORT_MODE_BIT - 16] && sec_master_abort; // [RULE7]

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      abort_read_data <= 32'h0000_0000;
    end else if (abort_read_all_ones) begin
      abort_read_data <= PBC_ALL_ONES; // [RULE7]
    end else begin
      abort_read_data <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // secondary reset sequencer
  // ----------------------------------------------------------------
  always_comb begin
    case (rst_state_r)
      PBC_RST_IDLE: rst_state_nxt = ctrl_r[PBC_SEC_RESET_BIT - 16] ? PBC_RST_HOLD : PBC_RST_IDLE;
      PBC_RST_HOLD: rst_state_nxt = ctrl_r[PBC_SEC_RESET_BIT - 16] ? PBC_RST_HOLD : PBC_RST_IDLE;
      default: rst_state_nxt = PBC_RST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rst_state_r <= PBC_RST_IDLE;
    end else begin
      rst_state_r <= rst_state_nxt; // [RULE9]
    end
  end

  assign sec1_bus_reset_n = rst_state_r != PBC_RST_HOLD; // [RULE9]
  assign sec2_bus_reset_n = rst_state_r != PBC_RST_HOLD; // [RULE9]

  assign fast_b2b_allowed = ctrl_r[PBC_FAST_B2B_BIT - 16]; // [RULE10]
endmodule

// ===== sim/pbc_props.sv
// checker for the bridge control dword, watching the top module ports only
// assumes one clock domain and rst asynchronous, active high
module pbc_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic pri_serr_enable,
  input wire logic pri_system_error_n,
  input wire logic fwd_down,
  input wire logic fwd_up,
  input wire logic abort_read_all_ones,
  input wire logic abort_signal_target,
  input wire logic [31:0] abort_read_data,
  input wire logic sec1_bus_reset_n,
  input wire logic sec2_bus_reset_n,
  input wire logic pri_mto_expired,
  input wire logic pri_disc_expired
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence mto_then_read;
    pri_mto_expired ##1 (cfg_rd && cfg_addr == 8'h3c);
  endsequence
  // a clearing write right behind still leaves one cycle of reset; any write there is excluded
  sequence srst_write;
    cfg_wr && cfg_addr == 8'h3c && cfg_be[2] && cfg_wdata[22] ##1 !cfg_wr;
  endsequence
  AST_RSV_ZERO: assert property ((cfg_rdata & 32'hf010_ffff) == 32'h0)
    else $error("reserved read bits not zero");
  AST_MTO_SET: assert property (mto_then_read |=> cfg_rdata[26])
    else $error("timeout status not set");
  AST_DISC_SERR: assert property (pri_disc_expired && pri_serr_enable |=> !pri_system_error_n)
    else $error("discard expiry gave no system error");
  AST_SRST_ON: assert property (srst_write |-> ##1 !sec1_bus_reset_n)
    else $error("secondary reset not driven");
  AST_SRST_PAIR: assert property (sec1_bus_reset_n == sec2_bus_reset_n)
    else $error("secondary resets differ");
  AST_ABORT_ONES: assert property (abort_read_all_ones |=> abort_read_data == 32'hffff_ffff)
    else $error("abort read data not all ones");
  AST_ABORT_EXCL: assert property (!(abort_read_all_ones && abort_signal_target))
    else $error("abort both reported and hidden");
  AST_UP_DOWN: assert property (!fwd_down |-> fwd_up)
    else $error("blocked io not passed upstream");
endmodule
bind pbc_bridge_control pbc_props chk (.core_clk, .rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata,
  .cfg_rdata, .pri_serr_enable, .pri_system_error_n, .fwd_down, .fwd_up, .abort_read_all_ones,
  .abort_signal_target, .abort_read_data, .sec1_bus_reset_n, .sec2_bus_reset_n, .pri_mto_expired,
  .pri_disc_expired);

// ===== sim/pbc_host_model.sv
// host software side: single configuration writes and reads toward the bridge
// assumes the testbench calls wr and rd; signals change on the falling edge
module pbc_host_model (
  input wire logic core_clk,
  input wire logic [31:0] cfg_rdata,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  initial {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = '0;
  // released data is inverted so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge core_clk) {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, a, be, d};
    @(negedge core_clk) {cfg_wr, cfg_be, cfg_wdata} = {1'b0, ~be, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge core_clk) {cfg_rd, cfg_addr} = {1'b1, a};
    @(negedge core_clk) cfg_rd = 1'b0;
    @(negedge core_clk) d = cfg_rdata;
  endtask
endmodule

// ===== sim/tb.sv
// self-checking bench for the bridge control dword with a host model
// assumes the design package and both sim modules are compiled first
module tb
  import pbc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, rst = 1'b1, cfg_wr, cfg_rd, sec_parity_err, sec_parity_report, pri_serr_enable;
  logic sec1_system_error_n, sec2_system_error_n, pri_system_error_n, io_in_window, vga_addr_hit, fwd_down;
  logic fwd_up, sec_master_abort, abort_target_possible, abort_signal_target, abort_read_all_ones;
  logic abort_discard_write, sec1_bus_reset_n, sec2_bus_reset_n, fast_b2b_allowed, dn, al;
  logic pri_mto_expired, sec_mto_expired, pri_disc_expired, sec1_disc_expired, sec2_disc_expired;
  logic [7:0] cfg_addr, c;
  logic [3:0] cfg_be, be;
  logic [1:0] sp;
  logic [31:0] cfg_wdata, cfg_rdata, io_addr, abort_read_data, d;
  int fails = 0, tests_run = 0;
  always #25 core_clk = ~core_clk;
  pbc_host_model host (.*);
  pbc_bridge_control dut (.*);
  // ----------------------------------------------------------------
  // expectations, compare and verdict
  // ----------------------------------------------------------------
  function automatic logic [31:0] exp_rd(input logic [7:0] cv, input logic [1:0] spv, input logic [1:0] s);
    return {4'h0, s, spv, cv & 8'hef, 16'h0};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdchk(input logic [31:0] e);
    host.rd(8'h3c, d);
    chk("bridge_control", e, d);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    final_report();
  end
  initial begin
    {sec_parity_err, io_addr, io_in_window, vga_addr_hit, sec_master_abort, abort_target_possible} = '0;
    {pri_mto_expired, sec_mto_expired, pri_disc_expired, sec1_disc_expired, sec2_disc_expired} = '0;
    {sec1_system_error_n, sec2_system_error_n, pri_serr_enable} = 3'h7;
    void'($urandom(5633));
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    rdchk(32'h0);
    for (int b = 16; b < 26; b++) begin
      host.wr(8'h3c, 4'hc, 32'h1 << b);
      rdchk(exp_rd(8'((32'h1 << b) >> 16), 2'((32'h1 << b) >> 24), 2'h0));
      {sec_parity_err, sec_master_abort, abort_target_possible} = 3'h7;
      #1 chk("effects", {25'h0, sec_parity_report, fast_b2b_allowed, sec1_bus_reset_n, sec2_bus_reset_n,
        abort_read_all_ones, abort_discard_write, abort_signal_target}, {25'h0, b == 16, b == 23, b != 22,
        b != 22, b != 21, b != 21, b == 21});
      abort_target_possible = 1'b0;
      repeat (2) @(negedge core_clk);
      chk("abort_serr", {31'h0, b != 21}, {31'h0, pri_system_error_n});
      abort_target_possible = 1'b1;
    end
    {c, sp} = {8'h00, 2'h2};
    repeat (20) begin
      {d, be} = {$urandom, 4'($urandom)};
      c = be[2] ? d[23:16] : c;
      sp = be[3] ? d[25:24] : sp;
      host.wr(8'h3c, be, d & 32'hf3ff_ffff);
      rdchk(exp_rd(c, sp, 2'h0));
    end
    host.wr(8'h40, 4'hf, 32'hffff_ffff);
    host.rd(8'h40, d);
    chk("unmapped", 32'h0, d);
    rdchk(exp_rd(c, sp, 2'h0));
    @(negedge core_clk) sec_mto_expired = 1'b1;
    @(negedge core_clk) {sec_mto_expired, sec2_disc_expired} = 2'h1;
    @(negedge core_clk) chk("serr_disc", 32'h0, {31'h0, pri_system_error_n});
    sec2_disc_expired = 1'b0;
    rdchk(exp_rd(c, sp, 2'h3));
    host.wr(8'h3c, 4'h8, 32'h0);
    sp = 2'h0;
    rdchk(exp_rd(c, sp, 2'h3));
    host.wr(8'h3c, 4'h8, 32'h0400_0000);
    rdchk(exp_rd(c, sp, 2'h2));
    host.wr(8'h3c, 4'h8, 32'h0800_0000);
    rdchk(exp_rd(c, sp, 2'h0));
    // primary timers held high so the clear below meets a live set event
    @(negedge core_clk) {pri_mto_expired, pri_disc_expired} = 2'h3;
    rdchk(exp_rd(c, sp, 2'h3));
    chk("serr_disc", 32'h0, {31'h0, pri_system_error_n});
    host.wr(8'h3c, 4'h8, 32'h0c00_0000);
    rdchk(exp_rd(c, sp, 2'h3));
    {pri_mto_expired, pri_disc_expired} = 2'h0;
    host.wr(8'h3c, 4'h8, 32'h0c00_0000);
    rdchk(exp_rd(c, sp, 2'h0));
    pri_serr_enable = 1'b0;
    @(negedge core_clk) pri_disc_expired = 1'b1;
    @(negedge core_clk) chk("serr_gate", 32'h1, {31'h0, pri_system_error_n});
    {pri_serr_enable, pri_disc_expired} = 2'h2;
    for (int k = 0; k < 2; k++) begin
      c = k ? 8'h00 : 8'h0e;
      host.wr(8'h3c, 4'h4, {8'h0, c, 16'h0});
      repeat (40) begin
        @(negedge core_clk) {io_addr, dn, vga_addr_hit} = {$urandom & 32'h0001_ffff, 2'($urandom)};
        io_in_window = dn & !vga_addr_hit;
        al = io_addr[9:0] >= 10'h100;
        dn = (vga_addr_hit & c[3]) | (io_in_window & !(c[2] & al & (io_addr[31:16] == 16'h0)));
        #1 chk("forward", {30'h0, dn, (c[2] & al) | !dn}, {30'h0, fwd_down, fwd_up});
      end
      for (int j = 0; j < 2; j++) begin
        {sec2_system_error_n, sec1_system_error_n} = j ? 2'h1 : 2'h2;
        repeat (5) @(negedge core_clk);
        chk("serr_fwd", {31'h0, !c[1]}, {31'h0, pri_system_error_n});
      end
      {sec2_system_error_n, sec1_system_error_n} = 2'h3;
    end
    final_report();
  end
endmodule
